// ==== dv/psm_host_model.sv ====
module psm_host_model
  import psm_pkg::*;
(
  // Clock.
  input wire logic mclk,
  // Decoded command toward the mode selector.
  output psm_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;

  initial cmd = '0;

  // One packet per call, valid for one cycle; the bits do not hold once it has gone.
  task automatic send(input logic toCore, input logic toNorth, input logic zeroN,
                      input logic oneN, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    cmd <= '{1'b1, toCore, toNorth, zeroN, oneN};
    @(posedge mclk);
    cmd <= '{1'b0, ~toCore, ~toNorth, ~zeroN, ~oneN};
  endtask
endmodule

// ==== dv/psm_power_state_select_properties.sv ====
module psm_power_state_select_properties
  import psm_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Observed ports.
  input wire logic enable,
  input wire logic porHigh,
  input wire logic phase2SenseHigh,
  input wire logic phase3SenseHigh,
  input psm_cmd_t cmd,
  input wire logic coreTransition,
  input wire logic northTransition,
  input wire logic convStart,
  input wire logic convSel,
  input wire logic convDone,
  input wire logic [CODE_W-1:0] convCode,
  input wire logic regWrite,
  input psm_mode_t coreMode,
  input psm_mode_t northMode,
  input psm_phase_t corePhaseCount,
  input psm_strap_t strapSettings,
  input wire logic strapDecoded,
  input wire logic strapCurrentOn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  // Mode selection follows addressed commands and transitions.
  property p_reset_ccm;
    $fell(reset) |-> coreMode == {PH_THREE, 1'b0} && !northMode.diodeEmulation;
  endproperty
  a_reset_ccm: assert property (p_reset_ccm) else $error("rail not in full ccm after reset");
  property p_core_dem;
    cmd.valid && cmd.coreSel && !cmd.powerStateZeroN && !coreTransition
      |=> coreMode == {PH_ONE, 1'b1};
  endproperty
  a_core_dem: assert property (p_core_dem) else $error("core not in one phase dem");
  property p_core_ccm;
    cmd.valid && cmd.coreSel && cmd.powerStateZeroN |=> coreMode == {corePhaseCount, 1'b0};
  endproperty
  a_core_ccm: assert property (p_core_ccm) else $error("core not in full ccm");
  property p_north_dem;
    cmd.valid && cmd.northSel && !cmd.powerStateZeroN && !northTransition
      |=> northMode == {PH_ONE, 1'b1};
  endproperty
  a_north_dem: assert property (p_north_dem) else $error("north not in one phase dem");
  property p_north_ccm;
    cmd.valid && cmd.northSel && cmd.powerStateZeroN
      |=> !northMode.diodeEmulation && northMode.phases != PH_THREE;
  endproperty
  a_north_ccm: assert property (p_north_ccm) else $error("north not in full ccm");
  // Porhigh settled for three cycles keeps phase latches out of the way.
  property p_north_hold;
    porHigh && $past(porHigh, 3) && !(cmd.valid && cmd.northSel) && !regWrite
      && !$past(regWrite) && !$past(regWrite, 2) && $stable(northTransition)
      && $past(northTransition) == $past(northTransition, 2) |=> $stable(northMode);
  endproperty
  a_north_hold: assert property (p_north_hold) else $error("north mode moved unaddressed");
  property p_transition_ccm;
    coreTransition && $past(coreTransition) |-> coreMode == {corePhaseCount, 1'b0};
  endproperty
  a_transition_ccm: assert property (p_transition_ccm) else $error("no ccm in transition");
  property p_phase_latch;
    $rose(enable) && !porHigh |-> ##[1:2] corePhaseCount ==
      (phase2SenseHigh ? PH_ONE : (phase3SenseHigh ? PH_TWO : PH_THREE));
  endproperty
  a_phase_latch: assert property (p_phase_latch) else $error("phase count wrong");
  property p_phase_frozen;
    porHigh && $past(porHigh, 3) |=> $stable(corePhaseCount);
  endproperty
  a_phase_frozen: assert property (p_phase_frozen) else $error("phase count moved");
  property p_decode_once;
    strapDecoded |-> !convStart ##1 strapDecoded;
  endproperty
  a_decode_once: assert property (p_decode_once) else $error("strap conversion repeated");
  property p_current_after;
    strapCurrentOn |-> strapDecoded;
  endproperty
  a_current_after: assert property (p_current_after) else $error("current on too early");
  property p_strap_b;
    convDone && convSel == SEL_B && !strapDecoded |-> ##2 strapDecoded
      && strapSettings[CODE_W-1:0] == $past(convCode, 2);
  endproperty
  a_strap_b: assert property (p_strap_b) else $error("second strap fields wrong");

  c_core_dem: cover property (cmd.valid && cmd.coreSel && !cmd.powerStateZeroN);
  c_decoded: cover property ($rose(strapDecoded));
  c_transition: cover property (coreTransition && coreMode.diodeEmulation);
endmodule

bind psm_power_state_select psm_power_state_select_properties u_props (.*);

// ==== dv/tb.sv ====
module tb
  import psm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [CODE_W-1:0] CODE_A = 7'h5A;
  localparam logic [CODE_W-1:0] CODE_B = 7'h35;
  localparam psm_mode_t FULL = '{PH_TWO, 1'b0};
  localparam psm_mode_t DIODE_EMULATION = '{PH_ONE, 1'b1};

  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic enable = 1'b0;
  logic porHigh = 1'b0;
  logic phase2SenseHigh = 1'b0;
  logic phase3SenseHigh = 1'b0;
  logic northSingleStrap = 1'b0;
  logic coreTransition = 1'b0;
  logic northTransition = 1'b0;
  logic convDone = 1'b0;
  logic [CODE_W-1:0] convCode = 7'h00;
  logic [ADDR_W-1:0] regAddr = 4'h0;
  logic [DATA_W-1:0] regWrData = 32'h0000_0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic convStart;
  logic convSel;
  logic strapDecoded;
  logic strapCurrentOn;
  psm_cmd_t cmd;
  psm_mode_t coreMode;
  psm_mode_t northMode;
  psm_phase_t corePhaseCount;
  psm_strap_t strapSettings;
  logic [DATA_W-1:0] rdVal;
  int errorCnt = 0;
  int comparisons = 0;
  int cycles = 0;

  psm_power_state_select u_dut (.*);
  psm_host_model u_host (.mclk(mclk), .cmd(cmd));

  // Free-running clock and a hang guard well above the expected run length.
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errorCnt++;
      $display("unexpected at %0t: run did not finish", $time);
      finalReport();
    end
  end

  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want,
                       input string what);
    comparisons++;
    if (seen !== want) begin
      errorCnt++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask

  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic regWr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic regRd(input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 rdVal = regRdData;
  endtask

  task automatic settle(input psm_mode_t core, input psm_mode_t north, input string what);
    repeat (3) @(posedge mclk);
    #1 check(coreMode, core, what);
    check(northMode, north, what);
  endtask

  // Converter stand-in: answers each start a few cycles late, then drives the inverse of its code.
  task automatic conv(input logic sel, input logic [CODE_W-1:0] code);
    int n;
    n = 0;
    #1;
    while (convStart !== 1'b1 && n < 60) begin
      @(posedge mclk);
      #1 n++;
    end
    check(convStart, 1'b1, "conversion start");
    check(convSel, sel, "conversion select");
    check(strapCurrentOn, 1'b0, "current source early");
    repeat (3) @(posedge mclk);
    convDone <= 1'b1;
    convCode <= code;
    @(posedge mclk);
    convDone <= 1'b0;
    convCode <= ~code;
  endtask

  task automatic testPhases();
    logic [1:0] straps [3] = '{2'b10, 2'b00, 2'b01};
    psm_phase_t want [3] = '{PH_ONE, PH_THREE, PH_TWO};
    #1 check(coreMode, {PH_THREE, 1'b0}, "core after reset");
    check(northMode, FULL, "north after reset");
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      {phase2SenseHigh, phase3SenseHigh} <= straps[i];
      enable <= 1'b1;
      repeat (4) @(posedge mclk);
      enable <= 1'b0;
      #1 check(corePhaseCount, want[i], "phase count");
    end
    @(posedge mclk);
    porHigh <= 1'b1;
    phase2SenseHigh <= 1'b1;
    @(posedge mclk);
    enable <= 1'b1;
    repeat (4) @(posedge mclk);
    #1 check(corePhaseCount, PH_TWO, "phase count frozen");
    $display("phase latch test done");
  endtask

  task automatic testStraps();
    int starts;
    starts = 0;
    conv(SEL_A, CODE_A);
    conv(SEL_B, CODE_B);
    repeat (3) @(posedge mclk);
    #1 check(strapDecoded, 1'b1, "decoded");
    check(strapCurrentOn, 1'b1, "current source");
    check(strapSettings[2*CODE_W-1:CODE_W], CODE_A, "first strap fields");
    check(strapSettings[CODE_W-1:0], CODE_B, "second strap fields");
    for (int i = 0; i < 60; i++) begin
      @(posedge mclk);
      #1 starts += int'(convStart === 1'b1);
    end
    check(starts, 0, "repeated conversion");
    $display("strap test done");
  endtask

  task automatic testCommands();
    logic [1:0] seq [4] = '{2'b01, 2'b00, 2'b11, 2'b10};
    psm_mode_t want;
    for (int r = 0; r < 2; r++) begin
      for (int i = 0; i < 4; i++) begin
        u_host.send(r == 0, r == 1, seq[i][1], seq[i][0], i);
        want = seq[i][1] ? FULL : DIODE_EMULATION;
        if (r == 0) begin
          settle(want, FULL, "core command");
        end else begin
          settle(FULL, want, "north command");
        end
      end
    end
    u_host.send(1'b0, 1'b0, 1'b0, 1'b1, 0);
    settle(FULL, FULL, "unaddressed command");
    $display("command test done");
  endtask

  task automatic testTransition();
    u_host.send(1'b1, 1'b1, 1'b0, 1'b1, 0);
    @(posedge mclk);
    coreTransition <= 1'b1;
    northTransition <= 1'b1;
    settle(FULL, FULL, "during transition");
    coreTransition <= 1'b0;
    northTransition <= 1'b0;
    settle(DIODE_EMULATION, DIODE_EMULATION, "after transition");
    $display("transition test done");
  endtask

  task automatic testRegisters();
    regWr(REG_CTRL, 32'h0000_0001);
    settle(FULL, FULL, "forced ccm");
    regRd(REG_MODE);
    check(rdVal, 32'h0000_01E4, "mode word");
    regWr(REG_CTRL, 32'h0000_0000);
    regRd(REG_CTRL);
    check(rdVal, DATA_ZERO, "control word");
    settle(DIODE_EMULATION, DIODE_EMULATION, "force released");
    regRd(4'h2);
    check(rdVal, DATA_ZERO, "unmapped read");
    regRd(REG_STRAP_A);
    check(rdVal, {25'h0, CODE_A}, "first code");
    regRd(REG_STRAP_B);
    check(rdVal, {25'h0, CODE_B}, "second code");
    $display("register test done");
  endtask

  // Main sequence.
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    testPhases();
    testStraps();
    testCommands();
    testTransition();
    testRegisters();
    finalReport();
  end
endmodule

// ==== hw/psm_phase_latch.sv ====
module psm_phase_latch
  import psm_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Enable and power-on reset status.
  input wire logic enable,
  input wire logic porHigh,
  // Comparator results and north strap.
  input wire logic phase2SenseHigh,
  input wire logic phase3SenseHigh,
  input wire logic northSingleStrap,
  // Latched phase counts.
  output psm_phase_t corePhases,
  output psm_phase_t northPhases
);

  logic enablePrev;
  logic next_enablePrev;
  psm_phase_t next_corePhases;
  psm_phase_t next_northPhases;

  // Capture on the enable rising edge, but only while power-on reset is low.
  // Once it is high the counts are frozen, so later strap noise is harmless.
  always_comb begin
    next_enablePrev = enable;
    next_corePhases = corePhases;
    next_northPhases = northPhases;
    if (enable && !enablePrev && !porHigh) begin
      if (phase2SenseHigh) begin
        next_corePhases = PH_ONE;
      end else if (phase3SenseHigh) begin
        next_corePhases = PH_TWO;
      end else begin
        next_corePhases = PH_THREE;
      end
      next_northPhases = northSingleStrap ? PH_ONE : PH_TWO;
    end
  end

  // Registers only.
  always_ff @(posedge mclk) begin
    if (reset) begin
      enablePrev <= 1'b0;
      corePhases <= PH_THREE;
      northPhases <= PH_TWO;
    end else begin
      enablePrev <= next_enablePrev;
      corePhases <= next_corePhases;
      northPhases <= next_northPhases;
    end
  end

endmodule

// ==== hw/psm_pkg.sv ====
package psm_pkg;

  // Register port geometry and byte offsets.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MODE = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STRAP_A = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STRAP_B = 4'hC;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Control and mode status field positions.
  localparam int CTRL_FORCE_BIT = 0;
  localparam int MODE_CORE_DEM = 0;
  localparam int MODE_CORE_PH = 1;
  localparam int MODE_NORTH_DEM = 3;
  localparam int MODE_NORTH_PH = 4;
  localparam int MODE_DECODED = 6;
  localparam int MODE_FORCE = 7;
  localparam int MODE_CURRENT = 8;

  // Strap converter code width and field positions.
  localparam int CODE_W = 7;
  localparam int OCP_W = 4;
  localparam int A_OCP_LSB = 3;
  localparam int A_DVC1 = 2;
  localparam int A_RAMP_CORE = 1;
  localparam int A_RAMP_NORTH = 0;
  localparam int B_DELAY = 6;
  localparam int B_DVC0 = 5;
  localparam int B_CORE_OFS = 4;
  localparam int B_NORTH_OFS = 3;
  localparam int B_ZERO_LL = 2;
  localparam int B_QR_CORE = 1;
  localparam int B_QR_NORTH = 0;
  localparam logic SEL_A = 1'b0;
  localparam logic SEL_B = 1'b1;

  // Strap settle time before the first conversion.
  localparam int CLK_NS = 40;
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (STRAP_SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_W = 5;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(SETTLE_CYC - 1);

  typedef enum logic [1:0] {
    PH_ONE = 2'b01,
    PH_TWO = 2'b10,
    PH_THREE = 2'b11
  } psm_phase_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b00,
    ST_CONV_A = 2'b01,
    ST_CONV_B = 2'b10,
    ST_DONE = 2'b11
  } psm_strap_st_t;

  typedef struct packed {
    logic valid;
    logic coreSel;
    logic northSel;
    logic powerStateZeroN;
    logic powerStateOneN;
  } psm_cmd_t;

  typedef struct packed {
    psm_phase_t phases;
    logic diodeEmulation;
  } psm_mode_t;

  typedef struct packed {
    logic [OCP_W-1:0] sustainedOvercurrentLimit;
    logic dynamicVoltageCompBit1;
    logic rampAmplitudeCore;
    logic rampAmplitudeNorth;
    logic overcurrentTriggerDelay;
    logic dynamicVoltageCompBit0;
    logic coreOffsetEn;
    logic northOffsetEn;
    logic northZeroLoadLine;
    logic quickResponseThresholdCore;
    logic quickResponseThresholdNorth;
  } psm_strap_t;

endpackage

// ==== hw/psm_power_state_select.sv ====
// Behaviour
// - After reset both rails run continuous conduction until a command says otherwise.
// - Core rail enters one-phase diode emulation on zero low, one high.
// - Core rail stays in one-phase diode emulation with both bits low.
// - Core zero bit high gives all configured phases in continuous conduction.
// - North rail enters one-phase diode emulation on zero low, one high.
// - North rail stays in one-phase diode emulation with both bits low.
// - North zero bit high returns to full-phase continuous conduction.
// - No phase strap asserted means three core phases.
// - Phase3 sense high gives two phases, phase2 sense high gives one.
// - Phase straps are sampled on the enable rising edge.
// - Phase count is taken only during power-on reset, then frozen.
// - Both strap pins are converted exactly once after power up, then held.
// - Strap current source turns on only after the one-time decode.
// - First strap gives overcurrent limit, compensation bit1, ramp amplitudes.
// - Second strap gives delay, bit0, offsets, zero load-line, quick thresholds.
// - A transition forces continuous conduction, then restores the saved mode.
module psm_power_state_select
  import psm_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,

  // Enable and power-on reset status.
  input wire logic enable,
  input wire logic porHigh,

  // Phase strap comparators.
  input wire logic phase2SenseHigh,
  input wire logic phase3SenseHigh,
  input wire logic northSingleStrap,

  // Decoded command from the serial link.
  input psm_cmd_t cmd,

  // Voltage transition in progress per rail.
  input wire logic coreTransition,
  input wire logic northTransition,

  // Strap converter handshake.
  output logic convStart,
  output logic convSel,
  input wire logic convDone,
  input wire logic [CODE_W-1:0] convCode,

  // Register port.
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,

  // Rail modes and decoded settings.
  output psm_mode_t coreMode,
  output psm_mode_t northMode,
  output psm_phase_t corePhaseCount,
  output psm_strap_t strapSettings,
  output logic strapDecoded,
  output logic strapCurrentOn
);

  // Latched north phase count; only the north rail logic reads it.
  psm_phase_t northPhaseCount;

  // Command hits per rail and the software force.
  logic coreHit;
  logic northHit;
  logic forceCcm;
  logic next_forceCcm;

  // Strap sequencer state and its settle counter.
  psm_strap_st_t state;
  psm_strap_st_t next_state;
  logic [SETTLE_W-1:0] settleCount;
  logic [SETTLE_W-1:0] next_settleCount;

  // Raw converter codes, kept so software can read them back.
  logic [CODE_W-1:0] codeA;
  logic [CODE_W-1:0] next_codeA;
  logic [CODE_W-1:0] codeB;
  logic [CODE_W-1:0] next_codeB;

  // Next values of the registered outputs.
  logic next_convStart;
  logic next_convSel;
  psm_strap_t next_strapSettings;
  logic next_strapDecoded;
  logic next_strapCurrentOn;
  logic [DATA_W-1:0] next_regRdData;

  // Status word assembled from live state for the mode register.
  logic [DATA_W-1:0] modeWord;

  // Phase counts are caught on each enable rising edge while power-on reset is low.
  // The latch watches the enable edge itself, so a board that raises
  // enable late still gets its straps read, as long as power-on reset
  // has not yet completed.
  psm_phase_latch phaseLatch (
    .mclk(mclk),
    .reset(reset),
    .enable(enable),
    .porHigh(porHigh),
    .phase2SenseHigh(phase2SenseHigh),
    .phase3SenseHigh(phase3SenseHigh),
    .northSingleStrap(northSingleStrap),
    .corePhases(corePhaseCount),
    .northPhases(northPhaseCount)
  );

  // A command moves a rail only when its own domain bit is set.
  assign coreHit = cmd.valid && cmd.coreSel;
  assign northHit = cmd.valid && cmd.northSel;

  // Core rail mode; software force acts like a transition.
  // The force is a bring-up aid: it pins both rails to full conduction
  // without losing the power-saving choice that the last command made.
  psm_rail_mode coreRail (
    .mclk(mclk),
    .reset(reset),
    .fullPhases(corePhaseCount),
    .cmdHit(coreHit),
    .powerStateZeroN(cmd.powerStateZeroN),
    .inTransition(coreTransition || forceCcm),
    .mode(coreMode)
  );

  // North rail mode. Both rails share one command bus; the domain bits
  // decide which of them takes a given packet.
  psm_rail_mode northRail (
    .mclk(mclk),
    .reset(reset),
    .fullPhases(northPhaseCount),
    .cmdHit(northHit),
    .powerStateZeroN(cmd.powerStateZeroN),
    .inTransition(northTransition || forceCcm),
    .mode(northMode)
  );

  // One-time strap sequence. The settle wait lets the divider voltage
  // stabilise after power-on reset before the first conversion starts.
  // Reaching ST_DONE is permanent until the next reset, which is what
  // keeps the decode to exactly one pass.
  // A dip of power-on reset during the settle wait restarts the wait, so
  // a glitching supply never starts a conversion on a moving divider.
  always_comb begin
    next_state = state;
    next_settleCount = settleCount;
    next_codeA = codeA;
    next_codeB = codeB;
    next_convStart = 1'b0;
    next_convSel = convSel;
    case (state)
      ST_WAIT: begin
        if (porHigh) begin
          if (settleCount == SETTLE_LAST) begin
            next_state = ST_CONV_A;
            next_convStart = 1'b1;
            next_convSel = SEL_A;
          end else begin
            next_settleCount = settleCount + 1'b1;
          end
        end else begin
          next_settleCount = '0;
        end
      end

      // First strap: capture, then start the second at once.
      ST_CONV_A: begin
        if (convDone) begin
          next_codeA = convCode;
          next_state = ST_CONV_B;
          next_convStart = 1'b1;
          next_convSel = SEL_B;
        end
      end

      // Second strap: capture and finish.
      ST_CONV_B: begin
        if (convDone) begin
          next_codeB = convCode;
          next_state = ST_DONE;
        end
      end

      // Terminal state; a converter done pulse here is ignored.
      ST_DONE: begin
        next_state = ST_DONE;
      end
      default: begin
        next_state = ST_WAIT;
      end
    endcase
  end

  // Strap sequence registers. The converter select is held between
  // starts so the converter may sample it at any time during a pass.
  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= ST_WAIT;
      settleCount <= '0;
      codeA <= '0;
      codeB <= '0;
      convStart <= 1'b0;
      convSel <= SEL_A;
    end else begin
      state <= next_state;
      settleCount <= next_settleCount;
      codeA <= next_codeA;
      codeB <= next_codeB;
      convStart <= next_convStart;
      convSel <= next_convSel;
    end
  end

  // Settings are published only after both codes are in, so downstream
  // logic never sees a half-decoded mix of old and new fields.
  // The current source is switched on with the same edge, which keeps
  // its extra divider voltage out of both conversions.
  always_comb begin
    next_strapSettings = strapSettings;
    next_strapDecoded = (state == ST_DONE);
    next_strapCurrentOn = (state == ST_DONE);
    if (state == ST_DONE && !strapDecoded) begin
      // First strap: limit, compensation bit 1 and ramp amplitudes.
      next_strapSettings.sustainedOvercurrentLimit =
        codeA[A_OCP_LSB +: OCP_W];
      next_strapSettings.dynamicVoltageCompBit1 = codeA[A_DVC1];
      next_strapSettings.rampAmplitudeCore = codeA[A_RAMP_CORE];
      next_strapSettings.rampAmplitudeNorth = codeA[A_RAMP_NORTH];

      // Second strap: delay, compensation bit 0, offsets and thresholds.
      next_strapSettings.overcurrentTriggerDelay = codeB[B_DELAY];
      next_strapSettings.dynamicVoltageCompBit0 = codeB[B_DVC0];
      next_strapSettings.coreOffsetEn = codeB[B_CORE_OFS];
      next_strapSettings.northOffsetEn = codeB[B_NORTH_OFS];
      next_strapSettings.northZeroLoadLine = codeB[B_ZERO_LL];
      next_strapSettings.quickResponseThresholdCore = codeB[B_QR_CORE];
      next_strapSettings.quickResponseThresholdNorth = codeB[B_QR_NORTH];
    end
  end

  // Settings registers.
  always_ff @(posedge mclk) begin
    if (reset) begin
      strapSettings <= '0;
      strapDecoded <= 1'b0;
      strapCurrentOn <= 1'b0;
    end else begin
      strapSettings <= next_strapSettings;
      strapDecoded <= next_strapDecoded;
      strapCurrentOn <= next_strapCurrentOn;
    end
  end

  // Mode status word assembled from live state.
  // Unused bits stay zero so that later fields can be added without
  // breaking software that masks the word.
  always_comb begin
    modeWord = DATA_ZERO;
    modeWord[MODE_CORE_DEM] = coreMode.diodeEmulation;
    modeWord[MODE_CORE_PH +: 2] = coreMode.phases;
    modeWord[MODE_NORTH_DEM] = northMode.diodeEmulation;
    modeWord[MODE_NORTH_PH +: 2] = northMode.phases;
    modeWord[MODE_DECODED] = strapDecoded;
    modeWord[MODE_FORCE] = forceCcm;
    modeWord[MODE_CURRENT] = strapCurrentOn;
  end

  // Register writes and reads. Read data stand for one cycle only and are
  // zero otherwise; an unmapped address reads as zero and ignores writes.
  always_comb begin
    next_forceCcm = forceCcm;
    next_regRdData = DATA_ZERO;

    // Only the control register is writable.
    if (regWrite && regAddr == REG_CTRL) begin
      next_forceCcm = regWrData[CTRL_FORCE_BIT];
    end

    // Reads never stall; every address answers in the next cycle.
    if (regRead) begin
      case (regAddr)
        REG_CTRL: begin
          next_regRdData[CTRL_FORCE_BIT] = forceCcm;
        end
        REG_MODE: begin
          next_regRdData = modeWord;
        end
        REG_STRAP_A: begin
          next_regRdData[CODE_W-1:0] = codeA;
        end
        REG_STRAP_B: begin
          next_regRdData[CODE_W-1:0] = codeB;
        end
        default: begin
          next_regRdData = DATA_ZERO;
        end
      endcase
    end
  end

  // Register port flip-flops. Clearing the read data between reads
  // makes a stale word easy to tell from a fresh one on the bus.
  always_ff @(posedge mclk) begin
    if (reset) begin
      forceCcm <= 1'b0;
      regRdData <= DATA_ZERO;
    end else begin
      forceCcm <= next_forceCcm;
      regRdData <= next_regRdData;
    end
  end

endmodule

// ==== hw/psm_rail_mode.sv ====
module psm_rail_mode
  import psm_pkg::*;
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Rail configuration and command.
  input psm_phase_t fullPhases,
  input wire logic cmdHit,
  input wire logic powerStateZeroN,
  input wire logic inTransition,
  // Rail mode.
  output psm_mode_t mode
);

  logic savedDem;
  logic next_savedDem;
  psm_mode_t next_mode;

  // The saved power-saving choice survives a transition, so the rail drops
  // back into it when the transition ends.
  always_comb begin
    next_savedDem = savedDem;
    if (cmdHit) begin
      next_savedDem = !powerStateZeroN;
    end
    if (inTransition || !next_savedDem) begin
      next_mode = '{fullPhases, 1'b0};
    end else begin
      next_mode = '{PH_ONE, 1'b1};
    end
  end

  // Registers only.
  always_ff @(posedge mclk) begin
    if (reset) begin
      savedDem <= 1'b0;
      mode <= '{fullPhases, 1'b0};
    end else begin
      savedDem <= next_savedDem;
      mode <= next_mode;
    end
  end

endmodule
